/* File: common/acc_pkg.sv */
// Package: register map, field positions, codes and timing for the converter control block
package acc_pkg;
    // Register offsets on the plain register port
    localparam logic [7:0] OFS_CTL_B = 8'h03;
    localparam logic [7:0] OFS_RES_LO = 8'h04;
    localparam logic [7:0] OFS_RES_HI = 8'h05;
    localparam logic [7:0] OFS_CSR = 8'h06;
    localparam logic [7:0] OFS_SEL = 8'h07;
    // Reset values
    localparam logic [7:0] CSR_RST = 8'h00;
    localparam logic [7:0] SEL_RST = 8'h00;
    localparam logic [7:0] CTL_B_RST = 8'h00;
    // Control/status, trigger and selector bit positions
    localparam int CSR_EN = 7;
    localparam int CSR_START = 6;
    localparam int CSR_ATE = 5;
    localparam int CSR_FLAG = 4;
    localparam int CSR_IE = 3;
    localparam int PS_MSB = 2;
    localparam int TRIG_MSB = 2;
    localparam int SEL_MSB = 5;
    localparam int GAIN_BIT = 0;
    localparam int SWAP_BIT = 5;
    // Conversion lengths in converter clocks
    localparam logic [4:0] CYC_FIRST = 5'h19;
    localparam logic [4:0] CYC_NORMAL = 5'h0D;
    // Selector codes
    localparam logic [5:0] SEL_SE_HI = 6'h07;
    localparam logic [5:0] SEL_DIFF_HI = 6'h1F;
    localparam logic [5:0] SEL_GND = 6'h20;
    localparam logic [5:0] SEL_IREF = 6'h21;
    localparam logic [5:0] SEL_TEMP = 6'h22;
    localparam logic [5:0] SEL_CAL_HI = 6'h27;
    // Core input indices beyond the eight pins, then the free running trigger source code
    localparam logic [3:0] IN_GND = 4'h8;
    localparam logic [3:0] IN_IREF = 4'h9;
    localparam logic [3:0] IN_TEMP = 4'hA;
    localparam logic [2:0] TRIG_FREE = 3'h0;

    typedef enum logic [0:0] {ST_IDLE = 1'b0, ST_CONV = 1'b1} acc_state_t;

    // Pair index (selector bits 4:1) to {positive, negative} input
    function automatic logic [7:0] acc_pair(input logic [3:0] idx);
        case (idx)
            4'h1: acc_pair = 8'h00;
            4'h2: acc_pair = 8'h33;
            4'h3: acc_pair = 8'h77;
            4'h4: acc_pair = 8'h01;
            4'h5: acc_pair = 8'h03;
            4'h6: acc_pair = 8'h12;
            4'h7: acc_pair = 8'h13;
            4'h8: acc_pair = 8'h23;
            4'h9: acc_pair = 8'h34;
            4'hA: acc_pair = 8'h35;
            4'hB: acc_pair = 8'h36;
            4'hC: acc_pair = 8'h37;
            4'hD: acc_pair = 8'h45;
            4'hE: acc_pair = 8'h56;
            4'hF: acc_pair = 8'h67;
            default: acc_pair = 8'h00;
        endcase
    endfunction : acc_pair

    // Last prescaler count for a divider code
    function automatic logic [6:0] acc_div_last(input logic [2:0] ps);
        logic [7:0] div;
        div = (ps < 3'h2) ? 8'h02 : (8'h01 << ps);
        acc_div_last = 7'(div - 8'h01);
    endfunction : acc_div_last
endpackage : acc_pkg

/* File: common/acc_sel_if.sv */
// Interface: selector code to decoded core routing
`timescale 1ns/1ps
`default_nettype none
interface acc_sel_if;
    logic [5:0] code;
    logic [3:0] pos;
    logic [3:0] neg;
    logic gain20;
    logic diff;
    logic temp;
    modport dec (input code, output pos, output neg, output gain20, output diff, output temp);
    modport user (output code, input pos, input neg, input gain20, input diff, input temp);
endinterface : acc_sel_if
`default_nettype wire

/* File: hdl/acc_mux_decode.sv */
// Selector decoder: single-ended, differential, calibration and temperature routing
`timescale 1ns/1ps
`default_nettype none
module acc_mux_decode
(
    acc_sel_if.dec sel
);
    import acc_pkg::*;

    always_comb
    begin
        logic [7:0] pr;
        pr = acc_pair(sel.code[4:1]);
        sel.pos = {1'b0, sel.code[2:0]};
        sel.neg = IN_GND;
        sel.gain20 = 1'b0;
        sel.diff = 1'b0;
        sel.temp = 1'b0;
        if (sel.code <= SEL_SE_HI)
        begin
            sel.pos = {1'b0, sel.code[2:0]};
        end
        else if (sel.code == SEL_GND)
        begin
            sel.pos = IN_GND;
        end
        else if (sel.code == SEL_IREF)
        begin
            sel.pos = IN_IREF;
        end
        else if (sel.code == SEL_TEMP)
        begin
            sel.pos = IN_TEMP;
            sel.temp = 1'b1;
        end
        else
        begin
            // Differential and calibration codes route a pair; calibration pairs tie one input to both sides
            sel.diff = 1'b1;
            sel.gain20 = sel.code[GAIN_BIT];
            if (sel.code[SWAP_BIT] && sel.code > SEL_CAL_HI)
            begin
                sel.pos = pr[3:0];
                sel.neg = pr[7:4];
            end
            else
            begin
                sel.pos = pr[7:4];
                sel.neg = pr[3:0];
            end
        end
    end
endmodule : acc_mux_decode
`default_nettype wire

/* File: hdl/acc_top.sv */
// Converter channel selection and conversion control with register port
//
// Notes on behaviour
// - Selector changes wait until conversion completes.
// - Codes route single-ended, ground, reference, pairs.
// - Temperature code enables the temperature sensor.
// - Reversed pair codes decode per mapping.
// - Lowest selector bit picks 1x or 20x.
// - Highest bit swaps pair polarity.
// - Calibration codes tie one input both sides.
// - Enable bit on; clearing aborts conversion.
// - Start bit begins single or first conversion.
// - First conversion 25 clocks, later 13; a start taken in the first one's done cycle also runs 25.
// - Start reads one while busy; zero ignored.
// - Auto-trigger starts on selected rising edge.
// - Done flag sets when result updated.
// - Interrupt needs flag, enable, global enable.
// - Flag clears by vector or written one.
// - Prescaler divides system clock per code.
// - Trigger source zero is free running.
//
// Our own choice: the strobed register port.
`timescale 1ns/1ps
`default_nettype none
module acc_top
(
    // Clock and reset
    input wire logic SYS_CLK_I,
    input wire logic RST_I,
    // Register port
    input wire logic [7:0] ADDR_I,
    input wire logic [7:0] WDATA_I,
    input wire logic WR_I,
    input wire logic RD_I,
    output logic [7:0] RDATA_O,
    // Processor side
    input wire logic GLOBAL_IRQ_EN_I,
    input wire logic IRQ_ACK_I,
    output logic CONV_IRQ_O,
    // Trigger flags, indexed by trigger source
    input wire logic [7:0] TRIG_I,
    // Analog core
    input wire logic [9:0] CORE_RESULT_I,
    output logic CORE_EN_O,
    output logic CORE_START_O,
    output logic [3:0] CORE_POS_O,
    output logic [3:0] CORE_NEG_O,
    output logic CORE_GAIN20_O,
    output logic CORE_DIFF_O,
    output logic TEMP_SENSOR_EN_O
);
    import acc_pkg::*;

    typedef struct packed {
        acc_state_t st;
        logic en;
        logic ate;
        logic flag;
        logic ie;
        logic [2:0] ps;
        logic [7:0] sel;
        logic [7:0] ctl_b;
        logic [5:0] act;
        logic [9:0] res;
        logic [6:0] pcnt;
        logic [4:0] tcnt;
        logic long_cnv;
        logic init_done;
        logic trig_prev;
        logic [7:0] rdata;
        logic start_pulse;
        logic irq;
        logic [3:0] pos;
        logic [3:0] neg;
        logic gain20;
        logic diff;
        logic temp;
    } acc_regs_t;

    acc_regs_t state_reg;
    acc_regs_t state_next;
    logic tick;
    logic done;
    acc_sel_if sel_bus ();

    // Decode from the held selection so the decoder never feeds its own source process;
    // routing settles one cycle after a new selection, far ahead of the core's sample point
    assign sel_bus.code = state_reg.act;

    acc_mux_decode u_dec (
        .sel(sel_bus)
    );

    always_comb
    begin
        logic wr_csr;
        logic start_req;
        logic trig_now;
        logic [2:0] src;
        logic [4:0] last;
        wr_csr = WR_I && (ADDR_I == OFS_CSR);
        src = state_reg.ctl_b[TRIG_MSB:0];
        trig_now = TRIG_I[src];
        last = state_reg.long_cnv ? CYC_FIRST : CYC_NORMAL;
        state_next = state_reg;
        state_next.start_pulse = 1'b0;
        state_next.trig_prev = trig_now;
        start_req = 1'b0;
        tick = state_reg.pcnt == acc_div_last(state_reg.ps);
        done = (state_reg.st == ST_CONV) && tick && (state_reg.tcnt == last - 5'h01);
        // Register writes
        if (wr_csr)
        begin
            state_next.en = WDATA_I[CSR_EN];
            state_next.ate = WDATA_I[CSR_ATE];
            state_next.ie = WDATA_I[CSR_IE];
            state_next.ps = WDATA_I[PS_MSB:0];
            if (WDATA_I[CSR_FLAG])
            begin
                state_next.flag = 1'b0;
            end
            // A written zero to start is simply not looked at
            start_req = WDATA_I[CSR_START];
        end
        if (WR_I && ADDR_I == OFS_SEL)
        begin
            state_next.sel = WDATA_I;
        end
        if (WR_I && ADDR_I == OFS_CTL_B)
        begin
            state_next.ctl_b = WDATA_I;
        end
        if (IRQ_ACK_I)
        begin
            state_next.flag = 1'b0;
        end
        // Edge on the selected flag; also fires when switching to a set source
        if (state_reg.ate && src != TRIG_FREE && trig_now && !state_reg.trig_prev)
        begin
            start_req = 1'b1;
        end
        // Prescaler runs only while enabled
        state_next.pcnt = (state_reg.en && !tick) ? 7'(state_reg.pcnt + 7'h01) : 7'h00;
        if (state_reg.st == ST_CONV && tick)
        begin
            state_next.tcnt = 5'(state_reg.tcnt + 5'h01);
        end
        if (done)
        begin
            state_next.st = ST_IDLE;
            state_next.res = CORE_RESULT_I;
            state_next.flag = 1'b1;
            state_next.init_done = 1'b1;
            if (state_reg.ate && src == TRIG_FREE)
            begin
                start_req = 1'b1;
            end
        end
        // New conversion; first one after enabling runs long
        if (start_req && state_next.en && (state_reg.st == ST_IDLE || done))
        begin
            state_next.st = ST_CONV;
            state_next.tcnt = 5'h00;
            state_next.pcnt = 7'h00;
            state_next.long_cnv = !state_reg.init_done || !state_reg.en;
            state_next.start_pulse = 1'b1;
        end
        // Selection follows the register only between conversions
        if (state_next.st == ST_IDLE || state_next.start_pulse)
        begin
            state_next.act = state_next.sel[SEL_MSB:0];
        end
        if (!state_next.en)
        begin
            state_next.st = ST_IDLE;
            state_next.init_done = 1'b0;
            state_next.start_pulse = 1'b0;
        end
        state_next.pos = sel_bus.pos;
        state_next.neg = sel_bus.neg;
        state_next.gain20 = sel_bus.gain20;
        state_next.diff = sel_bus.diff;
        state_next.temp = sel_bus.temp;
        state_next.irq = state_next.flag && state_next.ie && GLOBAL_IRQ_EN_I;
        // Read data
        state_next.rdata = 8'h00;
        if (RD_I)
        begin
            case (ADDR_I)
                OFS_CTL_B: state_next.rdata = state_reg.ctl_b;
                OFS_RES_LO: state_next.rdata = state_reg.res[7:0];
                OFS_RES_HI: state_next.rdata = {6'h00, state_reg.res[9:8]};
                OFS_CSR: state_next.rdata = {state_reg.en, state_reg.st == ST_CONV,
                    state_reg.ate, state_reg.flag, state_reg.ie, state_reg.ps};
                OFS_SEL: state_next.rdata = state_reg.sel;
                default: state_next.rdata = 8'h00;
            endcase
        end
    end

    always_ff @(posedge SYS_CLK_I or posedge RST_I)
    begin
        if (RST_I)
        begin
            state_reg <= '0;
            state_reg.sel <= SEL_RST;
            state_reg.ctl_b <= CTL_B_RST;
            state_reg.act <= SEL_RST[SEL_MSB:0];
        end
        else
        begin
            state_reg <= state_next;
        end
    end

    assign RDATA_O = state_reg.rdata;
    assign CONV_IRQ_O = state_reg.irq;
    assign CORE_EN_O = state_reg.en;
    assign CORE_START_O = state_reg.start_pulse;
    assign CORE_POS_O = state_reg.pos;
    assign CORE_NEG_O = state_reg.neg;
    assign CORE_GAIN20_O = state_reg.gain20;
    assign CORE_DIFF_O = state_reg.diff;
    assign TEMP_SENSOR_EN_O = state_reg.temp;

    // Helper: converter clocks counted independently of the sequencer
    logic [4:0] chk_ticks;
    always_ff @(posedge SYS_CLK_I or posedge RST_I)
    begin
        if (RST_I)
        begin
            chk_ticks <= 5'h00;
        end
        else if (state_next.start_pulse)
        begin
            chk_ticks <= 5'h00;
        end
        else if (state_reg.st == ST_CONV && tick)
        begin
            chk_ticks <= 5'(chk_ticks + 5'h01);
        end
    end

    default clocking cb @(posedge SYS_CLK_I); endclocking
    default disable iff (RST_I);

    a_sel_hold_busy: assert property (
        state_reg.st == ST_CONV && !state_reg.start_pulse && $past(state_reg.st == ST_CONV)
        |-> $stable(state_reg.act))
        else $error("selection changed during conversion");
    a_temp_sensor_on: assert property (
        state_reg.act == SEL_TEMP |=> TEMP_SENSOR_EN_O && CORE_POS_O == IN_TEMP)
        else $error("temperature sensor not enabled");
    a_gain_from_bit: assert property (
        sel_bus.diff |=> CORE_GAIN20_O == $past(state_reg.act[GAIN_BIT]))
        else $error("gain does not follow selector bit");
    a_disable_aborts: assert property (
        WR_I && ADDR_I == OFS_CSR && !WDATA_I[CSR_EN] |=> state_reg.st == ST_IDLE && !CORE_EN_O)
        else $error("conversion not aborted on disable");
    a_write_start_strobe: assert property (
        WR_I && ADDR_I == OFS_CSR && WDATA_I[CSR_EN] && WDATA_I[CSR_START]
        && state_reg.st == ST_IDLE |=> CORE_START_O && state_reg.st == ST_CONV)
        else $error("start write did not begin conversion");
    a_conv_length: assert property (
        done |-> chk_ticks + 5'h01 == (state_reg.long_cnv ? CYC_FIRST : CYC_NORMAL))
        else $error("conversion length wrong");
    a_flag_on_done: assert property (
        done |=> state_reg.flag && state_reg.res == $past(CORE_RESULT_I))
        else $error("flag or result not updated on completion");
    a_irq_gating: assert property (
        CONV_IRQ_O |-> $past(state_next.flag && state_next.ie && GLOBAL_IRQ_EN_I))
        else $error("interrupt without flag, enable and global enable");
    a_flag_clear_one: assert property (
        WR_I && ADDR_I == OFS_CSR && WDATA_I[CSR_FLAG] && !done |=> !state_reg.flag)
        else $error("flag not cleared by written one");
    a_sel_after_done: assert property (
        done && !(WR_I && ADDR_I == OFS_SEL)
        |=> state_reg.act == $past(state_reg.sel[SEL_MSB:0]))
        else $error("selection not applied after completion");
    a_abort_no_flag: assert property (
        WR_I && ADDR_I == OFS_CSR && !WDATA_I[CSR_EN] && !done && !state_reg.flag
        |=> !state_reg.flag)
        else $error("aborted conversion set the flag");
    a_prescale_half: assert property (
        (CORE_START_O && state_reg.ps < 3'h2) ##1 (CORE_EN_O && state_reg.ps < 3'h2)
        |-> tick)
        else $error("converter clock not at half the system clock");
    a_free_src_quiet: assert property (
        state_reg.st == ST_IDLE && state_reg.ctl_b[TRIG_MSB:0] == TRIG_FREE
        && !(WR_I && ADDR_I == OFS_CSR) |=> !CORE_START_O)
        else $error("start from free running source while idle");
    a_start_single: assert property (
        CORE_START_O
        |=> !CORE_START_O && (state_reg.st == ST_CONV || !CORE_EN_O))
        else $error("start strobe longer than one cycle");

    c_first_conversion: cover property (state_reg.long_cnv && done);
    c_free_running: cover property (done ##1 CORE_START_O);
    c_auto_trigger: cover property (state_reg.ate && state_reg.ctl_b[TRIG_MSB:0] != TRIG_FREE
        && CORE_START_O);
    c_interrupt: cover property ($rose(CONV_IRQ_O));
    c_abort: cover property (state_reg.st == ST_CONV ##1 !CORE_EN_O);
endmodule : acc_top
`default_nettype wire

/* File: testbench/acc_core_model.sv */
// Stand-in for the analog sampling core: the result encodes the routing it sees
`timescale 1ns/1ps
`default_nettype none
module acc_core_model
(
    // Routing from the control block
    input wire logic en_i,
    input wire logic [3:0] pos_i,
    input wire logic [3:0] neg_i,
    input wire logic gain20_i,
    input wire logic diff_i,
    // Sampled value
    output logic [9:0] result_o
);
    logic [9:0] route;
    assign route = {gain20_i, diff_i, pos_i, neg_i};
    // Powered down core gives garbage, so a capture while disabled shows up
    assign result_o = en_i ? route : ~route;
endmodule : acc_core_model
`default_nettype wire

/* File: testbench/tb_acc_top.sv */
// Bench for the converter control block: registers, decode and conversion timing
`timescale 1ns/1ps
`default_nettype none
module tb_acc_top;
    import acc_pkg::*;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic [7:0] addr = 8'h00;
    logic [7:0] wdata = 8'h00;
    logic wr_stb = 1'b0;
    logic rd_stb = 1'b0;
    logic gie = 1'b1;
    logic ack = 1'b0;
    logic [7:0] trig = 8'h00;
    logic [7:0] rdata;
    logic irq, en, start, g20, diff, temp, irq_q;
    logic [3:0] pos, neg;
    logic [9:0] res;
    logic [16:0] tbl [0:16];
    int num_errors = 0;
    int tests_run = 0;
    int cyc = 0;
    int lat = 0;
    int nstart = 0;
    int ticks = 0;
    int base = 0;

    always #2.5 clk = ~clk;

    acc_top u_dut (.SYS_CLK_I(clk), .RST_I(rst), .ADDR_I(addr), .WDATA_I(wdata),
        .WR_I(wr_stb), .RD_I(rd_stb), .RDATA_O(rdata), .GLOBAL_IRQ_EN_I(gie),
        .IRQ_ACK_I(ack), .CONV_IRQ_O(irq), .TRIG_I(trig), .CORE_RESULT_I(res),
        .CORE_EN_O(en), .CORE_START_O(start), .CORE_POS_O(pos), .CORE_NEG_O(neg),
        .CORE_GAIN20_O(g20), .CORE_DIFF_O(diff), .TEMP_SENSOR_EN_O(temp));
    acc_core_model u_core (.en_i(en), .pos_i(pos), .neg_i(neg), .gain20_i(g20),
        .diff_i(diff), .result_o(res));

    // Cycles since the last start pulse, latched when the request rises
    always @(posedge clk)
    begin
        cyc <= (start === 1'b1) ? 1 : cyc + 1;
        nstart <= nstart + ((start === 1'b1) ? 1 : 0);
        irq_q <= irq;
        if (irq === 1'b1 && irq_q !== 1'b1)
            lat <= cyc;
        ticks <= ticks + 1;
        if (ticks == 20000)
        begin
            num_errors++;
            results();
        end
    end

    task automatic results();
        $display("errors %0d of %0d checks", num_errors, tests_run);
        if (num_errors == 0 && tests_run > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask : results

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        tests_run++;
        if (got !== exp)
        begin
            num_errors++;
            $display("BAD t=%0t got %h expected %h", $time, got, exp);
        end
    endtask : chk

    task automatic tick(input int n);
        repeat (n) @(posedge clk);
    endtask : tick

    task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
        addr <= a;
        wdata <= d;
        wr_stb <= 1'b1;
        @(posedge clk);
        wr_stb <= 1'b0;
        @(posedge clk);
    endtask : wr_reg

    // Read data stand only in the cycle after the strobe
    task automatic rd_reg(input logic [7:0] a, input logic [7:0] e);
        addr <= a;
        rd_stb <= 1'b1;
        @(posedge clk);
        rd_stb <= 1'b0;
        @(posedge clk);
        chk({8'h00, rdata}, {8'h00, e});
    endtask : rd_reg

    task automatic wait_irq();
        int n;
        n = 0;
        while (irq !== 1'b1 && n < 3000)
        begin
            @(posedge clk);
            n++;
        end
        tick(2);
    endtask : wait_irq

    // Start, check busy, wait for completion, check length, flag and result
    task automatic conv(input logic [7:0] c, input int len, input logic [9:0] r);
        wr_reg(OFS_CSR, c);
        rd_reg(OFS_CSR, c);
        wait_irq();
        chk(16'(lat), 16'(len));
        rd_reg(OFS_CSR, c ^ 8'h50);
        rd_reg(OFS_RES_LO, r[7:0]);
        rd_reg(OFS_RES_HI, {6'h00, r[9:8]});
    endtask : conv

    initial
    begin
        tbl = '{{6'h00, 4'h0, 4'h8, 3'b000}, {6'h07, 4'h7, 4'h8, 3'b000},
            {6'h20, 4'h8, 4'h8, 3'b000}, {6'h21, 4'h9, 4'h8, 3'b000},
            {6'h22, 4'hA, 4'h8, 3'b001}, {6'h08, 4'h0, 4'h1, 3'b100},
            {6'h0B, 4'h0, 4'h3, 3'b110}, {6'h28, 4'h1, 4'h0, 3'b100},
            {6'h2D, 4'h2, 4'h1, 3'b110}, {6'h23, 4'h0, 4'h0, 3'b110},
            {6'h24, 4'h3, 4'h3, 3'b100}, {6'h25, 4'h3, 4'h3, 3'b110},
            {6'h26, 4'h7, 4'h7, 3'b100}, {6'h27, 4'h7, 4'h7, 3'b110},
            {6'h1F, 4'h6, 4'h7, 3'b110}, {6'h3F, 4'h7, 4'h6, 3'b110},
            {6'h13, 4'h3, 4'h4, 3'b110}};
        tick(8);
        rst <= 1'b0;
        tick(1);
        rd_reg(OFS_CSR, CSR_RST);
        rd_reg(OFS_SEL, SEL_RST);
        rd_reg(OFS_CTL_B, CTL_B_RST);
        rd_reg(OFS_RES_LO, 8'h00);
        wr_reg(8'h10, 8'hFF);
        rd_reg(8'h10, 8'h00);
        for (int i = 0; i < 17; i++)
        begin
            wr_reg(OFS_SEL, {2'b00, tbl[i][16:11]});
            tick(3);
            chk({5'h00, pos, neg, diff, g20, temp}, {5'h00, tbl[i][10:0]});
        end
        wr_reg(OFS_SEL, 8'h08);
        conv(8'hC8, 25 * 2, 10'h101);
        chk({15'h0000, en}, 16'h0001);
        wr_reg(OFS_CSR, 8'h98);
        tick(2);
        chk({15'h0000, irq}, 16'h0000);
        rd_reg(OFS_CSR, 8'h88);
        wr_reg(OFS_CSR, 8'hCB);
        wr_reg(OFS_CSR, 8'h8B);
        rd_reg(OFS_CSR, 8'hCB);
        wr_reg(OFS_SEL, 8'h3F);
        tick(20);
        chk({12'h000, pos}, 16'h0000);
        wait_irq();
        chk(16'(lat), 16'(13 * 8));
        rd_reg(OFS_RES_LO, 8'h01);
        chk({12'h000, pos}, 16'h0007);
        wr_reg(OFS_CSR, 8'h99);
        rd_reg(OFS_CSR, 8'h89);
        wr_reg(OFS_CSR, 8'hC9);
        tick(5);
        wr_reg(OFS_CSR, 8'h09);
        rd_reg(OFS_CSR, 8'h09);
        base = nstart;
        wr_reg(OFS_CSR, 8'h48);
        tick(60);
        chk({14'h0000, irq, en}, 16'h0000);
        chk(16'(nstart - base), 16'h0000);
        rd_reg(OFS_CSR, 8'h08);
        // Re-enabling after an aborted conversion forces the long first conversion
        conv(8'hC9, 25 * 2, 10'h376);
        ack <= 1'b1;
        tick(1);
        ack <= 1'b0;
        tick(2);
        chk({15'h0000, irq}, 16'h0000);
        rd_reg(OFS_CSR, 8'h89);
        gie <= 1'b0;
        wr_reg(OFS_CSR, 8'hC9);
        tick(40);
        chk({15'h0000, irq}, 16'h0000);
        rd_reg(OFS_CSR, 8'h99);
        gie <= 1'b1;
        tick(3);
        chk({15'h0000, irq}, 16'h0001);
        wr_reg(OFS_CSR, 8'h89);
        rd_reg(OFS_CSR, 8'h99);
        wr_reg(OFS_CSR, 8'h99);
        wr_reg(OFS_CTL_B, 8'h02);
        rd_reg(OFS_CTL_B, 8'h02);
        wr_reg(OFS_CSR, 8'hA9);
        base = nstart;
        trig <= 8'h04;
        wait_irq();
        chk(16'(lat), 16'(13 * 2));
        tick(40);
        chk(16'(nstart - base), 16'h0001);
        wr_reg(OFS_CTL_B, 8'h00);
        tick(5);
        chk(16'(nstart - base), 16'h0001);
        trig <= 8'h00;
        wr_reg(OFS_CSR, 8'hF9);
        base = nstart;
        tick(90);
        chk(16'(nstart - base), 16'h0004);
        wr_reg(OFS_CSR, 8'h00);
        tick(3);
        base = nstart;
        tick(60);
        chk(16'(nstart - base), 16'h0000);
        results();
    end
endmodule : tb_acc_top
`default_nettype wire
